/* inc/i2c_front_pkg.sv */
// Package with constants and carrier types for the two-wire target front end.
package i2c_front_pkg;

    // Fixed 7-bit target address, never configurable.
    localparam logic [6:0] TARGET_ADDR     = 7'h6C;
    // Direction bit value in bit 0 of the first byte.
    localparam logic       DIR_READ        = 1'b1;
    localparam logic       DIR_WRITE       = 1'b0;
    // Bits in one byte on the wire.
    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
    // Register address after reset.
    localparam logic [7:0] REG_ADDR_RESET  = 8'h00;
    // Read data value after reset.
    localparam logic [7:0] DATA_RESET      = 8'h00;

    // Bus phase.
    typedef enum logic [2:0] {
        PH_IDLE  = 3'b000,
        PH_ADDR  = 3'b001,
        PH_RECV  = 3'b010,
        PH_SEND  = 3'b011,
        PH_ACK   = 3'b100,
        PH_MACK  = 3'b101
    } phase_t;

    // Data handed to the register side after a written byte.
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } wr_beat_t;

endpackage

/* verilog/i2c_slave_address_front_end.sv */
// Two-wire target front end: conditions, address match, byte transfer.
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_address_front_end (
    // Clock and reset.
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    // Bus pins.
    input  wire logic                     scl_in,
    input  wire logic                     sda_in,
    output logic                          sda_out,
    output logic                          sda_oe,
    // Enable pin, active low.
    input  wire logic                     device_on_n,
    output logic                          device_on,
    // Register side.
    input  wire logic [7:0]               rd_data,
    output logic [7:0]                    reg_addr,
    output i2c_front_pkg::wr_beat_t       wr_beat,
    output logic                          selected,
    output logic                          is_read
);

    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [1:0] en_sync_reg;
    logic       scl_d_reg;
    logic       sda_d_reg;
    i2c_front_pkg::phase_t phase_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic       first_data_reg;
    logic       start_det;
    logic       stop_det;
    logic       scl_rise;
    logic       scl_fall;

    // Two-flop synchronisers; only the second stage is used downstream.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            en_sync_reg  <= 2'h3;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            en_sync_reg  <= {en_sync_reg[0], device_on_n};
        end
    end

    // Delayed copies for edge detection.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_sync_reg[1];
            sda_d_reg <= sda_sync_reg[1];
        end
    end

    assign start_det = scl_sync_reg[1] & scl_d_reg & sda_d_reg
                       & ~sda_sync_reg[1];
    assign stop_det  = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg
                       & sda_sync_reg[1];
    assign scl_rise  = scl_sync_reg[1] & ~scl_d_reg;
    assign scl_fall  = ~scl_sync_reg[1] & scl_d_reg;

    // enable pin
    // The enable acts alone; serial traffic never touches it.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            device_on <= 1'b0;
        end else begin
            device_on <= ~en_sync_reg[1];
        end
    end

    // Bit sampling on SCL rise, counting on SCL fall.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift_reg <= i2c_front_pkg::DATA_RESET;
        end else if (phase_reg == i2c_front_pkg::PH_SEND && scl_fall) begin
            shift_reg <= {shift_reg[6:0], 1'b1};
        end else if (phase_reg == i2c_front_pkg::PH_ACK && scl_fall
                     && is_read) begin
            shift_reg <= rd_data;
        end else if (phase_reg == i2c_front_pkg::PH_MACK && scl_fall) begin
            shift_reg <= rd_data;
        end else if (scl_rise && phase_reg != i2c_front_pkg::PH_SEND) begin
            // While sending, the rise must not shift, or bits are skipped.
            shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
        end
    end

    // Main phase sequencer; a START anywhere restarts the address phase.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase_reg      <= i2c_front_pkg::PH_IDLE;
            bit_cnt_reg    <= 4'h0;
            selected       <= 1'b0;
            is_read        <= 1'b0;
            first_data_reg <= 1'b0;
        end else if (start_det) begin
            phase_reg      <= i2c_front_pkg::PH_ADDR;
            bit_cnt_reg    <= 4'h0;
            selected       <= 1'b0;
            first_data_reg <= 1'b1;
        end else if (stop_det) begin
            phase_reg <= i2c_front_pkg::PH_IDLE;
            selected  <= 1'b0;
        end else if (scl_fall) begin
            unique case (phase_reg)
                i2c_front_pkg::PH_IDLE: begin
                    phase_reg <= i2c_front_pkg::PH_IDLE;
                end
                i2c_front_pkg::PH_ADDR: begin
                    // The fall after START is counted too, so the address
                    // byte is complete one count later than a data byte.
                    if (bit_cnt_reg == i2c_front_pkg::BITS_PER_BYTE) begin
                        bit_cnt_reg <= 4'h0;
                        if (shift_reg[7:1] == i2c_front_pkg::TARGET_ADDR) begin
                            selected  <= 1'b1;
                            is_read   <= (shift_reg[0] ==
                                          i2c_front_pkg::DIR_READ);
                            phase_reg <= i2c_front_pkg::PH_ACK;
                        end else begin
                            phase_reg <= i2c_front_pkg::PH_IDLE;
                        end
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                end
                i2c_front_pkg::PH_RECV,
                i2c_front_pkg::PH_SEND: begin
                    if (bit_cnt_reg ==
                        i2c_front_pkg::BITS_PER_BYTE - 4'h1) begin
                        bit_cnt_reg    <= 4'h0;
                        // Only the written byte right after the address loads the
                        // pointer; every later written byte is a data beat.
                        first_data_reg <= 1'b0;
                        phase_reg   <= (phase_reg == i2c_front_pkg::PH_RECV)
                                       ? i2c_front_pkg::PH_ACK
                                       : i2c_front_pkg::PH_MACK;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                end
                i2c_front_pkg::PH_ACK: begin
                    phase_reg <= is_read ? i2c_front_pkg::PH_SEND
                                         : i2c_front_pkg::PH_RECV;
                end
                i2c_front_pkg::PH_MACK: begin
                    phase_reg <= i2c_front_pkg::PH_SEND;
                end
                default: begin
                    phase_reg <= i2c_front_pkg::PH_IDLE;
                end
            endcase
        end else if (scl_rise && phase_reg == i2c_front_pkg::PH_MACK
                     && sda_sync_reg[1]) begin
            phase_reg <= i2c_front_pkg::PH_IDLE;
            selected  <= 1'b0;
        end
    end

    // address advance
    // The first written byte loads the pointer; later bytes step it.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_addr <= i2c_front_pkg::REG_ADDR_RESET;
            wr_beat  <= '0;
        end else begin
            wr_beat.valid <= 1'b0;
            if (scl_fall && phase_reg == i2c_front_pkg::PH_RECV
                && bit_cnt_reg == i2c_front_pkg::BITS_PER_BYTE - 4'h1) begin
                if (first_data_reg) begin
                    reg_addr <= shift_reg;
                end else begin
                    wr_beat.valid <= 1'b1;
                    wr_beat.addr  <= reg_addr;
                    wr_beat.data  <= shift_reg;
                    reg_addr      <= reg_addr + 8'h01;
                end
            end else if (scl_fall && phase_reg == i2c_front_pkg::PH_SEND
                         && bit_cnt_reg ==
                            i2c_front_pkg::BITS_PER_BYTE - 4'h1) begin
                // Step after each sent byte, so the next load sees it.
                reg_addr <= reg_addr + 8'h01;
            end
        end
    end

    // acknowledge drive
    // SDA is driven only low; release is the default when not selected.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            if (phase_reg == i2c_front_pkg::PH_ACK
                && !is_read_ack_skip()) begin
                sda_oe <= 1'b1;
            end else if (phase_reg == i2c_front_pkg::PH_SEND) begin
                sda_oe <= ~shift_reg[7];
            end else begin
                sda_oe <= 1'b0;
            end
        end
    end

    // Acknowledge only while selected; reads ack just the address byte.
    function automatic logic is_read_ack_skip();
        is_read_ack_skip = ~selected;
    endfunction

endmodule

`default_nettype wire

/* verification/i2c_front_chk.sv */
// Checker of the port behaviour of the two-wire target front end.
`timescale 1ns/1ps
`default_nettype none
module i2c_front_chk (
    // Clock, reset and pins.
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic                    scl_in,
    input  wire logic                    sda_in,
    input  wire logic                    sda_out,
    input  wire logic                    sda_oe,
    input  wire logic                    device_on_n,
    input  wire logic                    device_on,
    // Register side.
    input  wire logic [7:0]              reg_addr,
    input  wire i2c_front_pkg::wr_beat_t wr_beat,
    input  wire logic                    selected
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [7:0] beat_addr_reg;

    // The beat pulse lasts one cycle, so its address is kept for later.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            beat_addr_reg <= 8'h00;
        end else if (wr_beat.valid) begin
            beat_addr_reg <= wr_beat.addr;
        end
    end

    a_open_drain_low: assert property (!sda_out)
        else $error("data pin driven high");
    a_enable_follows_pin: assert property ($changed(device_on_n)
        |-> ##[1:5] (device_on == !device_on_n))
        else $error("enable output lags the pin");
    a_stop_ends_select: assert property (scl_in && $rose(sda_in)
        |-> ##[1:8] !selected)
        else $error("selection kept after stop");
    a_start_ends_select: assert property (scl_in && $fell(sda_in)
        |-> ##[1:8] !selected)
        else $error("selection kept after start");
    a_drive_needs_sel: assert property ($rose(sda_oe)
        |-> ##[0:2] selected)
        else $error("data pulled low while not selected");
    a_sda_steady_high: assert property ($rose(scl_in)
        |=> $stable(sda_oe) [*6])
        else $error("data drive changed while clock high");
    a_beat_one_cycle: assert property (wr_beat.valid
        |=> !wr_beat.valid)
        else $error("write beat longer than one cycle");
    a_pointer_steps: assert property ($fell(wr_beat.valid)
        |-> ##[0:3] (reg_addr == beat_addr_reg + 8'h01))
        else $error("pointer did not advance after beat");
endmodule
`default_nettype wire

/* verification/i2c_host_model.sv */
// Bus controller model that drives the clock and data lines.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    // Wire level of the data line.
    input  wire logic sda_line,
    // Controller side of the pins; high release means pulled up.
    output logic      scl,
    output logic      sda_rel
);
    localparam int HALF = 160;
    logic [7:0] rx;
    logic       ack;

    // Clock stands high and data is released outside frames.
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
        rx = 8'h00;
        ack = 1'b0;
    end

    task automatic start();
        #40 sda_rel = 1'b1;
        #HALF scl = 1'b1;
        #HALF sda_rel = 1'b0;
        #HALF scl = 1'b0;
    endtask

    task automatic stop();
        #40 sda_rel = 1'b0;
        #HALF scl = 1'b1;
        #HALF sda_rel = 1'b1;
        #HALF;
    endtask

    task automatic xfer(input logic [7:0] tx, input logic nack);
        for (int i = 8; i >= 0; i--) begin
            #40 sda_rel = (i > 0) ? tx[i-1] : nack;
            #HALF scl = 1'b1;
            if (i > 0) rx[i-1] = sda_line;
            ack = !sda_line;
            #HALF scl = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* verification/test_i2c_slave_address_front_end.sv */
// Self-checking bench of the two-wire target front end.
`timescale 1ns/1ps
`default_nettype none
module test_i2c_slave_address_front_end;
    logic                    sys_clk;
    logic                    rst;
    logic                    scl_in;
    logic                    sda_in;
    logic                    sda_out;
    logic                    sda_oe;
    logic                    sda_rel;
    logic                    device_on_n;
    logic                    device_on;
    logic                    selected;
    logic                    is_read;
    logic [7:0]              rd_data;
    logic [7:0]              reg_addr;
    logic [7:0]              mask;
    logic [7:0]              a;
    logic [6:0]              n;
    i2c_front_pkg::wr_beat_t wr_beat;
    i2c_front_pkg::wr_beat_t last_beat;
    int                      num_errors;
    int                      total_checks;
    int                      beats;
    int                      b;

    // Released data line reads as the pull-up level.
    assign sda_in = sda_rel & !sda_oe;
    assign rd_data = reg_addr ^ mask;
    i2c_slave_address_front_end dut_u (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .scl_in      (scl_in),
        .sda_in      (sda_in),
        .sda_out     (sda_out),
        .sda_oe      (sda_oe),
        .device_on_n (device_on_n),
        .device_on   (device_on),
        .rd_data     (rd_data),
        .reg_addr    (reg_addr),
        .wr_beat     (wr_beat),
        .selected    (selected),
        .is_read     (is_read)
    );
    i2c_host_model host_u (.sda_line(sda_in), .scl(scl_in),
                           .sda_rel(sda_rel));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = !sys_clk;
    end

    // Beats last one cycle, so they are caught as they pass.
    always @(posedge sys_clk) begin
        if (rst) begin
            beats     <= 0;
            last_beat <= '0;
        end else if (wr_beat.valid === 1'b1) begin
            last_beat <= wr_beat;
            beats <= beats + 1;
        end
    end

    function automatic logic [7:0] first_byte(input logic rd);
        return {7'h6C, rd};
    endfunction

    task automatic check(input string what, input logic [16:0] exp,
                         input logic [16:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic do_write(input logic [7:0] ad, input logic [7:0] dt);
        host_u.start();
        host_u.xfer(first_byte(1'b0), 1'b1);
        check("write ack", 1'h1, host_u.ack);
        check("write dir", 1'h0, is_read);
        host_u.xfer(ad, 1'b1);
        check("pointer", ad, reg_addr);
        host_u.xfer(dt, 1'b1);
        check("data ack", 1'h1, host_u.ack);
        host_u.stop();
        check("beat", {1'b1, ad, dt}, last_beat);
        check("pointer step", 8'(ad + 8'h01), reg_addr);
        check("stop release", 1'h0, selected);
    endtask

    // Pointer write, repeated start, two reads, the second refused.
    task automatic do_read(input logic [7:0] ad);
        host_u.start();
        host_u.xfer(first_byte(1'b0), 1'b1);
        host_u.xfer(ad, 1'b1);
        host_u.start();
        host_u.xfer(first_byte(1'b1), 1'b1);
        check("read ack", 1'h1, host_u.ack);
        check("direction", 1'h1, is_read);
        host_u.xfer(8'hFF, 1'b0);
        check("read 0", ad ^ mask, host_u.rx);
        host_u.xfer(8'hFF, 1'b1);
        check("read 1", 8'(ad + 8'h01) ^ mask, host_u.rx);
        check("nack release", 1'h0, selected);
        host_u.stop();
        check("pointer end", 8'(ad + 8'h02), reg_addr);
    endtask

    task automatic do_miss(input logic [6:0] ad7);
        b = beats;
        host_u.start();
        host_u.xfer({ad7, 1'b0}, 1'b1);
        check("miss ack", 1'h0, host_u.ack);
        host_u.xfer(8'h00, 1'b1);
        check("miss data ack", 1'h0, host_u.ack);
        host_u.stop();
        check("miss beats", 17'(b), 17'(beats));
    endtask

    initial begin
        #1_000_000;
        num_errors++;
        results();
    end

    initial begin
        rst = 1'b1;
        device_on_n = 1'b1;
        num_errors = 0;
        total_checks = 0;
        mask = 8'($urandom(30835));
        repeat (2) @(posedge sys_clk);
        #2 rst = 1'b0;
        repeat (5) @(posedge sys_clk);
        #2;
        for (int i = 0; i < 4; i++) begin
            device_on_n = i[0];
            repeat (6) @(posedge sys_clk);
            #2 check("device on", !i[0], device_on);
        end
        // Pointer wrap and near-miss addresses come first.
        do_write(8'hFF, 8'h00);
        do_read(8'hFF);
        do_miss(7'h6D);
        do_miss(7'h2C);
        repeat (4) begin
            a = 8'($urandom);
            mask = 8'($urandom);
            device_on_n = 1'($urandom);
            do_write(a, 8'($urandom));
            do_read(a);
            check("device on", !device_on_n, device_on);
            n = 7'($urandom);
            do_miss((n == 7'h6C) ? 7'h6E : n);
        end
        results();
    end
endmodule
bind i2c_slave_address_front_end i2c_front_chk chk_u (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .sda_out     (sda_out),
    .sda_oe      (sda_oe),
    .device_on_n (device_on_n),
    .device_on   (device_on),
    .reg_addr    (reg_addr),
    .wr_beat     (wr_beat),
    .selected    (selected)
);
`default_nettype wire
